// [e1rs_far_model.sv]
// Purpose: Far-side model of the rx slip buffer and the framer state lines
// Assumes: Bench commands are sampled on the rising edge, one per cycle
// Notes:   Fill level saturates, so only the design decides repeat or discard
`timescale 1ns/1ps
`default_nettype none
module e1rs_far_model
#(
    parameter int unsigned DEPTH = 2
)
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic wr_cmd,
    input  wire logic rd_cmd,
    input  wire logic pat_cmd,
    input  wire logic bfa_cmd,
    input  wire logic mfa_cmd,
    output var  logic rx_buf_empty,
    output var  logic rx_buf_full,
    output var  logic rx_buf_read,
    output var  logic rx_buf_write,
    output var  logic alt_pattern_detect,
    output var  logic basic_frame_aligned,
    output var  logic crc4_mf_aligned
);
    int unsigned fill_ff;
    assign rx_buf_empty = (fill_ff == 0);
    assign rx_buf_full  = (fill_ff == DEPTH);
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fill_ff             <= 0;
            rx_buf_read         <= 1'b0;
            rx_buf_write        <= 1'b0;
            alt_pattern_detect  <= 1'b0;
            basic_frame_aligned <= 1'b0;
            crc4_mf_aligned     <= 1'b0;
        end
        else
        begin
            rx_buf_read         <= rd_cmd;
            rx_buf_write        <= wr_cmd;
            alt_pattern_detect  <= pat_cmd;
            basic_frame_aligned <= bfa_cmd;
            crc4_mf_aligned     <= mfa_cmd;
            // A write into a full buffer or a read of an empty one leaves the level alone
            if (rx_buf_write && !rx_buf_full)
                fill_ff <= fill_ff + 1;
            else if (rx_buf_read && !rx_buf_empty)
                fill_ff <= fill_ff - 1;
        end
    end
endmodule : e1rs_far_model
`default_nettype wire

// [e1rs_flag.sv]
// Purpose: Sticky event flag with set winning over clear
// Assumes: Set and clear come from logic on the same clock
// Notes:   Set in the clear cycle keeps the flag high
`timescale 1ns/1ps
`default_nettype none
module e1rs_flag
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic clr,
    output var  logic flag
);
    logic flag_ff;
    logic nxt_flag;

    assign nxt_flag = set | (flag_ff & ~clr);
    assign flag     = flag_ff;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            flag_ff <= 1'b0;
        else
            flag_ff <= nxt_flag;
    end
endmodule : e1rs_flag
`default_nettype wire

// [e1rs_iw_timer.sv]
// Purpose: Counts clocks while the CRC-4 multiframe search runs
// Assumes: run drops whenever the search is abandoned
// Notes:   expired is a level that holds while run stays high
`timescale 1ns/1ps
`default_nettype none
module e1rs_iw_timer
#(
    parameter int unsigned CYCLES = 16000000
)
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic run,
    output var  logic expired
);
    localparam logic [31:0] LIMIT = 32'(CYCLES);

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;

    // Saturate so a long wait cannot wrap into a false second expiry
    assign nxt_cnt = !run ? 32'h0000_0000 :
                     (cnt_ff == LIMIT) ? cnt_ff : cnt_ff + 32'h0000_0001;
    assign expired = run && (cnt_ff == LIMIT);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cnt_ff <= 32'h0000_0000;
        else
            cnt_ff <= nxt_cnt;
    end
endmodule : e1rs_iw_timer
`default_nettype wire

// [e1rs_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts for the E1 rx status block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Definitions only
`ifndef E1RS_PARAMS_SVH
`define E1RS_PARAMS_SVH

`define E1RS_BYTE_ADDR(i)       {2'b00, (i), 2'b00}
`define E1RS_IDX_CFG            12'h107
`define E1RS_IDX_SLIP_EN        12'hB08
`define E1RS_IDX_SLIP_STAT      12'hB09
`define E1RS_IDX_LOOP_STAT      12'hB0A
`define E1RS_IDX_LOOP_EN        12'hB0B

`define E1RS_SLIP_BIT           0
`define E1RS_EMPTY_BIT          1
`define E1RS_IWCHG_BIT          4
`define E1RS_IWSTATE_BIT        5
`define E1RS_ALTCHG_BIT         6
`define E1RS_ALTPRES_BIT        7
`define E1RS_CFG_ANNEXB_BIT     0
`define E1RS_CFG_CRC4_BIT       1

`define E1RS_SLIP_EN_MASK       8'h03
`define E1RS_LOOP_EN_MASK       8'h50
`define E1RS_CFG_MASK           8'h03
`define E1RS_REG_RESET          8'h00

`define E1RS_CLK_HZ             64'd40000000
`define E1RS_IW_TIME_MS         64'd400
`define E1RS_IW_CYCLES          ((`E1RS_IW_TIME_MS * `E1RS_CLK_HZ) / 64'd1000)

`endif

// [e1rs_pkg.sv]
// Purpose: Types shared by the E1 rx status block
// Assumes: Constants live in e1rs_params.svh
// Notes:   Types only
package e1rs_pkg;
    typedef logic [15:0] e1rs_addr_t;
    typedef logic [31:0] e1rs_word_t;
    typedef logic [7:0]  e1rs_reg_t;
    typedef enum logic { IW_CRC4, IW_NONCRC4 } e1rs_iw_state_t;
endpackage : e1rs_pkg

// [e1rs_rx_status.sv]
// Purpose: E1 rx slip, auxiliary pattern and interworking status with APB registers
// Assumes: Framer and slip buffer inputs come from logic on the same clock
// Notes:   Status flags are set only while their enable bit is 1
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "e1rs_params.svh"
module e1rs_rx_status
#(
    parameter int unsigned IW_CYCLES = 32'(`E1RS_IW_CYCLES)
)
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire e1rs_pkg::e1rs_addr_t paddr,
    input  wire e1rs_pkg::e1rs_word_t pwdata,
    output var  e1rs_pkg::e1rs_word_t prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    input  wire logic               rx_buf_empty,
    input  wire logic               rx_buf_full,
    input  wire logic               rx_buf_read,
    input  wire logic               rx_buf_write,
    input  wire logic               alt_pattern_detect,
    input  wire logic               basic_frame_aligned,
    input  wire logic               crc4_mf_aligned,
    output var  logic               rx_frame_repeat,
    output var  logic               rx_frame_discard,
    output var  logic               irq
);
    import e1rs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    logic       setup_ph;
    logic       acc_ph;
    logic       wr_acc;
    logic       rd_acc;
    logic       hit_cfg;
    logic       hit_slip_en;
    logic       hit_slip_stat;
    logic       hit_loop_stat;
    logic       hit_loop_en;
    logic       hit_any;
    e1rs_reg_t  wdata8;

    assign setup_ph      = psel && !penable;
    assign acc_ph        = psel && penable;
    assign wr_acc        = acc_ph && pwrite && hit_any;
    assign rd_acc        = acc_ph && !pwrite && hit_any;
    assign hit_cfg       = paddr == `E1RS_BYTE_ADDR(`E1RS_IDX_CFG);
    assign hit_slip_en   = paddr == `E1RS_BYTE_ADDR(`E1RS_IDX_SLIP_EN);
    assign hit_slip_stat = paddr == `E1RS_BYTE_ADDR(`E1RS_IDX_SLIP_STAT);
    assign hit_loop_stat = paddr == `E1RS_BYTE_ADDR(`E1RS_IDX_LOOP_STAT);
    assign hit_loop_en   = paddr == `E1RS_BYTE_ADDR(`E1RS_IDX_LOOP_EN);
    assign hit_any       = hit_cfg | hit_slip_en | hit_slip_stat | hit_loop_stat | hit_loop_en;
    assign wdata8        = pwdata[7:0];
    // No wait state; read data comes from a flop loaded in the setup phase
    assign pready        = acc_ph;
    assign pslverr       = acc_ph && !hit_any;

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    e1rs_reg_t cfg_ff;
    e1rs_reg_t slip_en_ff;
    e1rs_reg_t loop_en_ff;
    e1rs_reg_t nxt_cfg;
    e1rs_reg_t nxt_slip_en;
    e1rs_reg_t nxt_loop_en;

    assign nxt_cfg     = (wr_acc && hit_cfg) ? (wdata8 & `E1RS_CFG_MASK) : cfg_ff;
    assign nxt_slip_en = (wr_acc && hit_slip_en) ? (wdata8 & `E1RS_SLIP_EN_MASK) : slip_en_ff;
    assign nxt_loop_en = (wr_acc && hit_loop_en) ? (wdata8 & `E1RS_LOOP_EN_MASK) : loop_en_ff;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_ff     <= `E1RS_REG_RESET;
            slip_en_ff <= `E1RS_REG_RESET;
            loop_en_ff <= `E1RS_REG_RESET;
        end
        else
        begin
            cfg_ff     <= nxt_cfg;
            slip_en_ff <= nxt_slip_en;
            loop_en_ff <= nxt_loop_en;
        end
    end

    logic annex_b_mode_enable;
    logic crc4_align_enable;
    logic rx_buffer_empty_irq_enable;
    logic rx_buffer_slip_irq_enable;
    logic alt_pattern_change_irq_enable;
    logic interworking_change_irq_enable;

    assign annex_b_mode_enable            = cfg_ff[`E1RS_CFG_ANNEXB_BIT];
    assign crc4_align_enable              = cfg_ff[`E1RS_CFG_CRC4_BIT];
    assign rx_buffer_empty_irq_enable     = slip_en_ff[`E1RS_EMPTY_BIT];
    assign rx_buffer_slip_irq_enable      = slip_en_ff[`E1RS_SLIP_BIT];
    assign alt_pattern_change_irq_enable  = loop_en_ff[`E1RS_ALTCHG_BIT];
    assign interworking_change_irq_enable = loop_en_ff[`E1RS_IWCHG_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Slip buffer events

    logic underflow;
    logic overflow;
    logic repeat_ff;
    logic discard_ff;

    assign underflow = rx_buf_empty && rx_buf_read;
    assign overflow  = rx_buf_full && rx_buf_write;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            repeat_ff  <= 1'b0;
            discard_ff <= 1'b0;
        end
        else
        begin
            repeat_ff  <= underflow;
            discard_ff <= overflow;
        end
    end

    assign rx_frame_repeat  = repeat_ff;
    assign rx_frame_discard = discard_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Auxiliary pattern and interworking state

    logic           alt_pattern_present_ff;
    e1rs_iw_state_t iw_state_ff;
    e1rs_iw_state_t nxt_iw_state;
    logic           iw_run;
    logic           iw_expired;
    logic           iw_keep;
    logic           alt_change;
    logic           iw_change;

    // Search is abandoned as soon as any precondition drops, restarting the wait
    assign iw_run  = annex_b_mode_enable && crc4_align_enable && basic_frame_aligned
                     && !crc4_mf_aligned && (iw_state_ff == IW_CRC4);
    assign iw_keep = annex_b_mode_enable && basic_frame_aligned && !crc4_mf_aligned;
    always_comb
    begin
        nxt_iw_state = iw_state_ff;
        case (iw_state_ff)
            IW_CRC4:
                if (iw_expired)
                    nxt_iw_state = IW_NONCRC4;
            IW_NONCRC4:
                if (!iw_keep)
                    nxt_iw_state = IW_CRC4;
            default:
                nxt_iw_state = IW_CRC4;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alt_pattern_present_ff <= 1'b0;
            iw_state_ff            <= IW_CRC4;
        end
        else
        begin
            alt_pattern_present_ff <= alt_pattern_detect;
            iw_state_ff            <= nxt_iw_state;
        end
    end
    assign alt_change = alt_pattern_detect != alt_pattern_present_ff;
    assign iw_change  = nxt_iw_state != iw_state_ff;

    e1rs_iw_timer #(.CYCLES(IW_CYCLES)) u_iw_timer
    (
        .clock   (clock),
        .rst_n   (rst_n),
        .run     (iw_run),
        .expired (iw_expired)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky status flags

    e1rs_reg_t rd_mux;
    e1rs_reg_t prdata_ff;
    logic      slip_w1c;
    logic      loop_w1c;
    logic      loop_rd;
    logic      rx_empty_flag;
    logic      rx_slip_flag;
    logic      alt_pattern_change_flag;
    logic      interworking_change_flag;

    assign slip_w1c = wr_acc && hit_slip_stat;
    assign loop_w1c = wr_acc && hit_loop_stat;
    // Only bits already shown to software are cleared, so a late event survives the read
    assign loop_rd  = rd_acc && hit_loop_stat;

    e1rs_flag u_empty_flag
    (
        .clock (clock),
        .rst_n (rst_n),
        .set   (underflow && rx_buffer_empty_irq_enable),
        .clr   (slip_w1c && wdata8[`E1RS_EMPTY_BIT]),
        .flag  (rx_empty_flag)
    );

    e1rs_flag u_slip_flag
    (
        .clock (clock),
        .rst_n (rst_n),
        .set   ((underflow || overflow) && rx_buffer_slip_irq_enable),
        .clr   (slip_w1c && wdata8[`E1RS_SLIP_BIT]),
        .flag  (rx_slip_flag)
    );

    e1rs_flag u_alt_flag
    (
        .clock (clock),
        .rst_n (rst_n),
        .set   (alt_change && alt_pattern_change_irq_enable),
        .clr   ((loop_rd && prdata_ff[`E1RS_ALTCHG_BIT])
                || (loop_w1c && wdata8[`E1RS_ALTCHG_BIT])),
        .flag  (alt_pattern_change_flag)
    );

    e1rs_flag u_iw_flag
    (
        .clock (clock),
        .rst_n (rst_n),
        .set   (iw_change && interworking_change_irq_enable),
        .clr   ((loop_rd && prdata_ff[`E1RS_IWCHG_BIT])
                || (loop_w1c && wdata8[`E1RS_IWCHG_BIT])),
        .flag  (interworking_change_flag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read path and interrupt

    logic      interworking_state;
    e1rs_reg_t slip_stat_view;
    e1rs_reg_t loop_stat_view;

    assign interworking_state = annex_b_mode_enable && (iw_state_ff == IW_NONCRC4);
    assign slip_stat_view = {6'h00, rx_empty_flag, rx_slip_flag};
    assign loop_stat_view = {alt_pattern_present_ff, alt_pattern_change_flag,
                             interworking_state, interworking_change_flag, 4'h0};
    assign rd_mux = hit_cfg       ? cfg_ff :
                    hit_slip_en   ? slip_en_ff :
                    hit_slip_stat ? slip_stat_view :
                    hit_loop_stat ? loop_stat_view :
                    hit_loop_en   ? loop_en_ff : 8'h00;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            prdata_ff <= 8'h00;
        else if (setup_ph && !pwrite)
            prdata_ff <= rd_mux;
    end
    assign prdata = {24'h00_0000, prdata_ff};
    assign irq = (rx_empty_flag && rx_buffer_empty_irq_enable)
               || (rx_slip_flag && rx_buffer_slip_irq_enable)
               || (alt_pattern_change_flag && alt_pattern_change_irq_enable)
               || (interworking_change_flag && interworking_change_irq_enable);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_loop_setup_rd;
        setup_ph && !pwrite && hit_loop_stat;
    endsequence
    sequence s_loop_rd_done;
        acc_ph && !pwrite && hit_loop_stat;
    endsequence

    a_repeat_on_under: assert property (underflow |=> rx_frame_repeat)
        else $error("frame repeat missing after underflow");
    a_discard_on_over: assert property (overflow |=> rx_frame_discard)
        else $error("frame discard missing after overflow");
    a_empty_flag_set: assert property
        (underflow && rx_buffer_empty_irq_enable |=> rx_empty_flag ##0 irq)
        else $error("empty flag or irq not raised");
    a_slip_flag_gate: assert property
        (!rx_buffer_slip_irq_enable && !$past(rx_slip_flag) && !slip_w1c
         |-> !rx_slip_flag || $past(rx_buffer_slip_irq_enable))
        else $error("slip flag set while disabled");
    a_alt_follows: assert property
        (1'b1 |=> alt_pattern_present_ff == $past(alt_pattern_detect))
        else $error("pattern state does not follow detector");
    a_alt_change_set: assert property
        ($changed(alt_pattern_present_ff) && $past(alt_pattern_change_irq_enable)
         |-> alt_pattern_change_flag)
        else $error("pattern change flag missed");
    a_read_clears: assert property
        (s_loop_setup_rd ##1 (s_loop_rd_done ##0 (prdata_ff[`E1RS_ALTCHG_BIT]
         && !(alt_change && alt_pattern_change_irq_enable))) |=> !alt_pattern_change_flag)
        else $error("pattern change flag not cleared by read");
    a_iw_declared: assert property (iw_expired |=> iw_state_ff == IW_NONCRC4)
        else $error("interworking not declared after timeout");
    a_iw_gated: assert property (!annex_b_mode_enable |-> !interworking_state)
        else $error("interworking shown without annex-B mode");
    a_iw_change_set: assert property
        ($changed(iw_state_ff) && $past(interworking_change_irq_enable)
         |-> interworking_change_flag)
        else $error("interworking change flag missed");
    a_irq_quiet: assert property
        (!rx_empty_flag && !rx_slip_flag && !alt_pattern_change_flag
         && !interworking_change_flag |-> !irq)
        else $error("irq high with no status set");
    a_unmapped_err: assert property (acc_ph && !hit_any |-> pready && pslverr)
        else $error("unmapped access not flagged");
endmodule : e1rs_rx_status
`default_nettype wire

// [tb_e1_rx_slip_and_pattern_status.sv]
// Purpose: Self-checking bench for the E1 rx status block
// Assumes: Zero-wait APB slave; interworking timer shortened to 20 cycles
// Notes:   Slip, pattern and interworking events come from the far-side model
`timescale 1ns/1ps
`default_nettype none
`include "e1rs_params.svh"
module tb_e1_rx_slip_and_pattern_status;
    import e1rs_pkg::*;
    localparam e1rs_addr_t A_CFG  = `E1RS_BYTE_ADDR(`E1RS_IDX_CFG);
    localparam e1rs_addr_t A_SEN  = `E1RS_BYTE_ADDR(`E1RS_IDX_SLIP_EN);
    localparam e1rs_addr_t A_SST  = `E1RS_BYTE_ADDR(`E1RS_IDX_SLIP_STAT);
    localparam e1rs_addr_t A_LST  = `E1RS_BYTE_ADDR(`E1RS_IDX_LOOP_STAT);
    localparam e1rs_addr_t A_LEN  = `E1RS_BYTE_ADDR(`E1RS_IDX_LOOP_EN);
    logic       clock = 1'b0, rst_n = 1'b0;
    logic       psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    e1rs_addr_t paddr = 16'h0000;
    e1rs_word_t pwdata = 32'h00000000, prdata;
    logic       pready, pslverr, irq, rx_frame_repeat, rx_frame_discard;
    logic       wr_cmd = 1'b0, rd_cmd = 1'b0, pat_cmd = 1'b0, bfa_cmd = 1'b0, mfa_cmd = 1'b0;
    logic       b_empty, b_full, b_read, b_write, alt_det, bfa, mfa;
    int         err_total = 0, check_count = 0, rep_cnt = 0, disc_cnt = 0;
    initial
    begin
        forever #12.5 clock = ~clock;
    end
    e1rs_rx_status #(.IW_CYCLES(20)) dut (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_buf_empty(b_empty),
        .rx_buf_full(b_full), .rx_buf_read(b_read), .rx_buf_write(b_write),
        .alt_pattern_detect(alt_det), .basic_frame_aligned(bfa), .crc4_mf_aligned(mfa),
        .rx_frame_repeat(rx_frame_repeat), .rx_frame_discard(rx_frame_discard), .irq(irq));
    e1rs_far_model #(.DEPTH(2)) far (.clock(clock), .rst_n(rst_n), .wr_cmd(wr_cmd),
        .rd_cmd(rd_cmd), .pat_cmd(pat_cmd), .bfa_cmd(bfa_cmd), .mfa_cmd(mfa_cmd),
        .rx_buf_empty(b_empty), .rx_buf_full(b_full), .rx_buf_read(b_read),
        .rx_buf_write(b_write), .alt_pattern_detect(alt_det), .basic_frame_aligned(bfa),
        .crc4_mf_aligned(mfa));
    always @(posedge clock)
    begin
        if (rx_frame_repeat === 1'b1) rep_cnt++;
        if (rx_frame_discard === 1'b1) disc_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input e1rs_reg_t got, input e1rs_reg_t exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input e1rs_addr_t a, input e1rs_reg_t wd,
                       output e1rs_reg_t rd, output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h000000, wd};
        @(posedge clock);
        penable <= 1'b1;
        // Slave may stretch the access phase; the wait stays bounded
        for (n = 0; n < 16; n++)
        begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 16)
        begin
            err_total++;
            $display("mismatch at %0t: no pready within the wait bound", $time);
            end_of_test();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input e1rs_addr_t a, input e1rs_reg_t d);
        e1rs_reg_t v;
        logic e;
        apb(1'b1, a, d, v, e);
    endtask : wr
    task automatic rd_chk(input e1rs_addr_t a, input e1rs_reg_t exp, input string msg);
        e1rs_reg_t v;
        logic e;
        apb(1'b0, a, 8'h00, v, e);
        chk(v, exp, msg);
    endtask : rd_chk
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        e1rs_reg_t v;
        logic e;
        rd_chk(A_SEN, 8'h00, "slip enable reset");
        rd_chk(A_LEN, 8'h00, "companion enable reset");
        rd_chk(A_LST, 8'h00, "loop status reset");
        wr(A_SEN, 8'hFF);
        rd_chk(A_SEN, 8'h03, "slip enable rw bits");
        wr(A_LEN, 8'hFF);
        rd_chk(A_LEN, 8'h50, "companion enable rw bits");
        wr(A_LST, 8'hFF);
        rd_chk(A_LST, 8'h00, "read-only status ignores writes");
        apb(1'b0, 16'h0010, 8'h00, v, e);
        chk({7'h00, e}, 8'h01, "unmapped read error");
        wr(A_SEN, 8'h00);
        wr(A_LEN, 8'h00);
    endtask : t_regs
    task automatic t_underflow();
        wr(A_SEN, 8'h03);
        @(posedge clock) rd_cmd <= 1'b1;
        @(posedge clock) rd_cmd <= 1'b0;
        repeat (4) @(posedge clock);
        chk(8'(rep_cnt), 8'h01, "one frame repeated");
        chk({7'h00, irq}, 8'h01, "irq on underflow");
        rd_chk(A_SST, 8'h03, "empty and slip flags");
        wr(A_SST, 8'h03);
        // The clear lands on the access edge, so look one edge later
        @(posedge clock);
        chk({7'h00, irq}, 8'h00, "irq cleared");
        rd_chk(A_SST, 8'h00, "flags cleared");
    endtask : t_underflow
    task automatic t_overflow();
        wr(A_SEN, 8'h01);
        @(posedge clock) wr_cmd <= 1'b1;
        repeat (4) @(posedge clock);
        wr_cmd <= 1'b0;
        repeat (4) @(posedge clock);
        chk(8'(disc_cnt), 8'h02, "two frames discarded back to back");
        chk(8'(rep_cnt), 8'h01, "no repeat on overflow");
        rd_chk(A_SST, 8'h01, "slip flag only, empty masked");
        wr(A_SST, 8'h01);
        wr(A_SEN, 8'h00);
        @(posedge clock) rd_cmd <= 1'b1;
        repeat (3) @(posedge clock);
        rd_cmd <= 1'b0;
        repeat (4) @(posedge clock);
        chk(8'(rep_cnt), 8'h02, "third read of two frames repeats");
        rd_chk(A_SST, 8'h00, "masked underflow sets no flag");
        chk({7'h00, irq}, 8'h00, "irq stays low when masked");
    endtask : t_overflow
    task automatic t_pattern();
        @(posedge clock) pat_cmd <= 1'b1;
        repeat (4) @(posedge clock);
        rd_chk(A_LST, 8'h80, "present, change masked");
        pat_cmd <= 1'b0;
        wr(A_LEN, 8'h40);
        @(posedge clock) pat_cmd <= 1'b1;
        repeat (4) @(posedge clock);
        chk({7'h00, irq}, 8'h01, "irq on pattern start");
        rd_chk(A_LST, 8'hC0, "start sets change flag");
        rd_chk(A_LST, 8'h80, "change flag cleared by read");
        chk({7'h00, irq}, 8'h00, "irq low after read");
        @(posedge clock) pat_cmd <= 1'b0;
        repeat (4) @(posedge clock);
        rd_chk(A_LST, 8'h40, "stop sets change flag");
        rd_chk(A_LST, 8'h00, "cleared again");
        wr(A_LEN, 8'h00);
    endtask : t_pattern
    task automatic t_interwork();
        wr(A_LEN, 8'h10);
        @(posedge clock) bfa_cmd <= 1'b1;
        wr(A_CFG, 8'h03);
        repeat (8) @(posedge clock);
        rd_chk(A_LST, 8'h00, "no declaration before timeout");
        repeat (20) @(posedge clock);
        rd_chk(A_LST, 8'h30, "non-CRC-4 declared with change");
        rd_chk(A_LST, 8'h20, "state holds, change cleared");
        @(posedge clock) mfa_cmd <= 1'b1;
        repeat (4) @(posedge clock);
        rd_chk(A_LST, 8'h10, "return to CRC-4 flags change");
        wr(A_CFG, 8'h02);
        @(posedge clock) mfa_cmd <= 1'b0;
        repeat (40) @(posedge clock);
        rd_chk(A_LST, 8'h00, "no detection without annex-B");
        wr(A_CFG, 8'h01);
        repeat (40) @(posedge clock);
        rd_chk(A_LST, 8'h00, "no detection without CRC-4 alignment enabled");
    endtask : t_interwork
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_underflow();
        t_overflow();
        t_pattern();
        t_interwork();
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("mismatch at %0t: run did not finish in time", $time);
        end_of_test();
    end
endmodule : tb_e1_rx_slip_and_pattern_status
`default_nettype wire
